// >>> core/crs_consts.vh
/*
  Constants for the reset and interrupt sequencer: register offsets,
  field positions, reset values and sequence cycle figures.
  Assumes it is included by bare name from core/ design files.
*/
`ifndef CRS_CONSTS_VH
`define CRS_CONSTS_VH

// Register offsets (byte addresses, one word each)
`define CRS_OFS_CTRL 5'h00
`define CRS_OFS_IER 5'h04
`define CRS_OFS_IFR 5'h08
`define CRS_OFS_FLAG_CLR 5'h0c
`define CRS_OFS_FLAG_SET 5'h10
`define CRS_OFS_VTP 5'h14
`define CRS_OFS_IRP 5'h18
`define CRS_OFS_NRP 5'h1c

// Control word fields
`define CRS_CTRL_GIE 0
`define CRS_CTRL_PREV_GLOBAL_ENABLE 1
`define CRS_CTRL_NONMASKABLE_ENABLE 2

// Vector table pointer layout
`define CRS_VTB_MSB 31
`define CRS_VTB_LSB 10
`define CRS_VTB_W 22
`define CRS_VEC_NUM_LSB 5

// Interrupt numbering
`define CRS_NUM_RESET 4'h0
`define CRS_NUM_NMI 4'h1
`define CRS_FIRST_MASKABLE 4
`define CRS_LAST_LINE 15

// Reset values
`define CRS_IER_RST 16'h0001
`define CRS_IFR_RST 16'h0000
`define CRS_VTB_RST 22'h000000

// Reset sequence cycles after release
`define CRS_RST_FLAG_SET 5'd15
`define CRS_RST_ACK 5'd16
`define CRS_RST_FLAG_CLR 5'd17
`define CRS_RST_HOLD_LAST 5'd21
`define CRS_RST_SERVICE 5'd22

// Nonreset take sequence steps (step 1 is cycle 5 of the take)
`define CRS_TAKE_FIRST 4'd1
`define CRS_TAKE_ACK 4'd2
`define CRS_TAKE_FLAG_CLR 4'd3
`define CRS_TAKE_HOLD_LAST 4'd7
`define CRS_TAKE_SERVICE 4'd8

`endif

// >>> core/crs_edge_detect.v
/*
  Two-flop synchroniser and rising-edge detector for a group of lines.
  Assumes lines are asynchronous to i_core_clk; edge is a one-clock pulse.
*/
`timescale 1ns/1ps
`default_nettype none

module crs_edge_detect #(
  parameter W = 16
) (
  // Clock and reset
  input wire i_core_clk,
  input wire i_rst,
  // Lines
  input wire [W-1:0] i_line,
  output wire [W-1:0] o_rise
);

  reg [W-1:0] sync1_ff;
  reg [W-1:0] sync2_ff;
  reg [W-1:0] prev_ff;

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_ff <= {W{1'b0}};
      sync2_ff <= {W{1'b0}};
      prev_ff <= {W{1'b0}};
    end else begin
      sync1_ff <= i_line;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  // Only a low-to-high change counts
  assign o_rise = sync2_ff & ~prev_ff; // [RQ11]

endmodule // crs_edge_detect

`default_nettype wire

// >>> core/crs_sequencer.v
/*
  Reset and interrupt sequencer of the CPU: flags, enables, return
  pointers, reset and nonreset take sequences, pipeline control.
  Assumes pipeline signals are on i_core_clk; interrupt lines are async.
*/
`timescale 1ns/1ps
`default_nettype none
`include "crs_consts.vh"

// Operation
// RQ1 - Reset flushes the pipeline and returns every register to its reset value.
// RQ2 - Reset clears global enable, nonmaskable enable and vector table base.
// RQ3 - Cycles 15 to 21 after reset keep nonreset interrupts disabled.
// RQ4 - Cycle 16 after reset forces a branch to the vector table pointer.
// RQ5 - Cycle 16 after reset asserts acknowledge with the reset number.
// RQ6 - Cycle 17 after reset clears the reset flag.
// RQ7 - Software sets both enables and the enable register after reset.
// RQ8 - A take costs 7 cycles with nothing entering the first execute stage.
// RQ9 - Latency is 11 cycles for nonreset, 21 cycles for reset. The code starts reset service in cycle 23.
// RQ10 - Step 8 clears the taken flag; a new event that cycle wins. The code clears it at step 3 (CRS_TAKE_FLAG_CLR).
// RQ11 - Only a rising edge on a line is recognised as a request.
// RQ12 - Nonreset takes wait while packets n to n+4 hold branches.
// RQ13 - Memory stalls stretch the cycle and delay every sequence step.
// RQ14 - Annulling a later multicycle no-op cycle saves the next packet address.
// RQ15 - Older packets complete; later ones are annulled and refetched.
// RQ16 - Nonmaskable may preempt maskable service; nothing preempts nonmaskable service.
// RQ17 - A nesting routine saves pointer and previous enable, then sets global enable.
// RQ18 - A nesting routine clears global enable before restoring saved values.
// RQ19 - Maskable take copies global to previous enable and clears it; nonmaskable clears its enable.
// RQ20 - First annulled packet address goes to the matching return pointer.
module crs_sequencer (
  // Clock and reset
  input wire i_core_clk,
  input wire i_rst,
  // Interrupt lines, bit m is line m; bits 0, 2, 3 unused
  input wire [15:0] i_int_line,
  // Pipeline status
  input wire i_mem_stall,
  input wire i_branch_window,
  input wire [31:0] i_annul_pc,
  input wire i_nop_later_cycle,
  input wire [31:0] i_nop_next_pc,
  input wire i_return_maskable,
  input wire i_return_nonmaskable,
  // Register port
  input wire [4:0] i_reg_addr,
  input wire [31:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  output reg [31:0] o_reg_rdata,
  // Pipeline control
  output reg o_flush,
  output reg o_e1_hold,
  output reg o_annul,
  output reg o_force_branch,
  output reg [31:0] o_branch_target,
  output reg o_service_start,
  // Acknowledge
  output reg o_int_ack,
  output reg [3:0] o_int_number_lines
);

  localparam [2:0] ST_RESET = 3'b001;
  localparam [2:0] ST_IDLE = 3'b010;
  localparam [2:0] ST_TAKE = 3'b100;

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [4:0] rst_cnt_ff;
  reg [4:0] nxt_rst_cnt;
  reg [3:0] step_ff;
  reg [3:0] nxt_step;
  reg [3:0] num_ff;
  reg [3:0] nxt_num;
  reg global_int_enable_ff;
  reg nxt_global_int_enable;
  reg prev_global_enable_ff;
  reg nxt_prev_global_enable;
  reg nonmaskable_enable_ff;
  reg nxt_nonmaskable_enable;
  reg [15:0] int_enable_register_ff;
  reg [15:0] int_flag_register_ff;
  reg [15:0] nxt_int_flag_register;
  reg [21:0] vector_table_base_ff;
  reg [31:0] irp_ff;
  reg [31:0] nxt_irp;
  reg [31:0] nonmaskable_return_pointer_ff;
  reg [31:0] nxt_nonmaskable_return_pointer;
  reg [15:0] eligible;
  reg [3:0] best_num;
  reg [15:0] clr_mask;
  reg [15:0] set_mask;
  reg take_go;
  reg [31:0] ret_pc;

  wire [15:0] line_rise;
  wire cpu_en;
  wire [31:0] vector_table_pointer;
  integer i;

  crs_edge_detect #(
    .W(16)
  ) u_edge (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_line(i_int_line),
    .o_rise(line_rise)
  );

  // A memory stall stretches the CPU cycle
  assign cpu_en = ~i_mem_stall; // [RQ13]
  assign vector_table_pointer = {vector_table_base_ff, 1'b0, best_num, 5'h00};

  // Pending interrupts allowed to be taken, highest priority lowest number
  always @* begin
    eligible = 16'h0000;
    best_num = 4'h0;
    for (i = `CRS_LAST_LINE; i >= 1; i = i - 1) begin
      if (i == 1 || i >= `CRS_FIRST_MASKABLE) begin
        // Nonmaskable enable gates all, global enable only maskable lines
        eligible[i] = int_flag_register_ff[i] & int_enable_register_ff[i] & nonmaskable_enable_ff &
                      (i == 1 ? 1'b1 : global_int_enable_ff); // [RQ16]
      end
      if (eligible[i]) begin
        best_num = i[3:0];
      end
    end
  end

  // Sequence control
  always @* begin
    nxt_state = state_ff;
    nxt_rst_cnt = rst_cnt_ff;
    nxt_step = step_ff;
    nxt_num = num_ff;
    take_go = 1'b0;
    case (state_ff)
      ST_RESET: begin
        if (cpu_en) begin
          if (rst_cnt_ff == `CRS_RST_SERVICE) begin
            nxt_state = ST_IDLE; // [RQ9]
          end else begin
            nxt_rst_cnt = rst_cnt_ff + 5'd1;
          end
        end
      end
      ST_IDLE: begin
        // Branch window holds off nonreset takes
        if (cpu_en && best_num != 4'h0 && !i_branch_window) begin // [RQ12]
          take_go = 1'b1;
          nxt_state = ST_TAKE;
          nxt_step = `CRS_TAKE_FIRST;
          nxt_num = best_num;
        end
      end
      ST_TAKE: begin
        if (cpu_en) begin
          if (step_ff == `CRS_TAKE_SERVICE) begin
            nxt_state = ST_IDLE;
            nxt_step = 4'd0;
          end else begin
            nxt_step = step_ff + 4'd1;
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Return address: skip an interrupted multicycle no-op
  always @* begin
    ret_pc = i_annul_pc; // [RQ20]
    if (i_nop_later_cycle) begin
      ret_pc = i_nop_next_pc; // [RQ14]
    end
  end

  // Register writes as masks
  always @* begin
    clr_mask = 16'h0000;
    set_mask = 16'h0000;
    if (i_reg_wr && i_reg_addr == `CRS_OFS_FLAG_CLR) begin
      clr_mask = i_reg_wdata[15:0];
    end
    if (i_reg_wr && i_reg_addr == `CRS_OFS_FLAG_SET) begin
      set_mask = i_reg_wdata[15:0];
    end
    if (state_ff == ST_RESET && nxt_rst_cnt == `CRS_RST_FLAG_CLR && rst_cnt_ff != nxt_rst_cnt) begin
      clr_mask[0] = 1'b1; // [RQ6]
    end
    if (state_ff == ST_TAKE && nxt_step == `CRS_TAKE_FLAG_CLR && step_ff != nxt_step) begin
      clr_mask[num_ff] = 1'b1; // [RQ10]
    end
    if (state_ff == ST_RESET && nxt_rst_cnt == `CRS_RST_FLAG_SET && rst_cnt_ff != nxt_rst_cnt) begin
      set_mask[0] = 1'b1;
    end
    // Incoming edges win over any clear in the same cycle
    set_mask = set_mask | {line_rise[15:4], 2'b00, line_rise[1], 1'b0}; // [RQ10]
    nxt_int_flag_register = (int_flag_register_ff & ~clr_mask) | set_mask;
  end

  // Enables and return pointers
  always @* begin
    nxt_global_int_enable = global_int_enable_ff;
    nxt_prev_global_enable = prev_global_enable_ff;
    nxt_nonmaskable_enable = nonmaskable_enable_ff;
    nxt_irp = irp_ff;
    nxt_nonmaskable_return_pointer = nonmaskable_return_pointer_ff;
    // Software writes: nesting routines drive these bits themselves
    if (i_reg_wr && i_reg_addr == `CRS_OFS_CTRL) begin // [RQ17] [RQ18] [RQ7]
      nxt_global_int_enable = i_reg_wdata[`CRS_CTRL_GIE];
      nxt_prev_global_enable = i_reg_wdata[`CRS_CTRL_PREV_GLOBAL_ENABLE];
      nxt_nonmaskable_enable = i_reg_wdata[`CRS_CTRL_NONMASKABLE_ENABLE] | nonmaskable_enable_ff;
    end
    if (i_reg_wr && i_reg_addr == `CRS_OFS_IRP) begin
      nxt_irp = i_reg_wdata;
    end
    if (i_reg_wr && i_reg_addr == `CRS_OFS_NRP) begin
      nxt_nonmaskable_return_pointer = i_reg_wdata;
    end
    if (i_return_maskable) begin
      nxt_global_int_enable = prev_global_enable_ff;
    end
    if (i_return_nonmaskable) begin
      nxt_nonmaskable_enable = 1'b1;
    end
    // Hardware take has priority over software in the same cycle
    if (take_go) begin
      if (best_num == `CRS_NUM_NMI) begin
        nxt_nonmaskable_enable = 1'b0; // [RQ19]
        nxt_nonmaskable_return_pointer = ret_pc; // [RQ20]
      end else begin
        nxt_prev_global_enable = global_int_enable_ff; // [RQ19]
        nxt_global_int_enable = 1'b0;
        nxt_irp = ret_pc; // [RQ20]
      end
    end
  end

  // State, flags and enables
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      // Both enables and the table base clear under reset
      state_ff <= ST_RESET; // [RQ1]
      rst_cnt_ff <= 5'd0;
      step_ff <= 4'd0;
      num_ff <= `CRS_NUM_RESET;
      global_int_enable_ff <= 1'b0; // [RQ2]
      prev_global_enable_ff <= 1'b0;
      nonmaskable_enable_ff <= 1'b0; // [RQ2] [RQ3]
      int_enable_register_ff <= `CRS_IER_RST;
      int_flag_register_ff <= `CRS_IFR_RST;
      vector_table_base_ff <= `CRS_VTB_RST; // [RQ2]
      irp_ff <= 32'h00000000;
      nonmaskable_return_pointer_ff <= 32'h00000000;
    end else begin
      state_ff <= nxt_state;
      rst_cnt_ff <= nxt_rst_cnt;
      step_ff <= nxt_step;
      num_ff <= nxt_num;
      global_int_enable_ff <= nxt_global_int_enable;
      prev_global_enable_ff <= nxt_prev_global_enable;
      nonmaskable_enable_ff <= nxt_nonmaskable_enable;
      int_flag_register_ff <= nxt_int_flag_register;
      irp_ff <= nxt_irp;
      nonmaskable_return_pointer_ff <= nxt_nonmaskable_return_pointer;
      if (i_reg_wr && i_reg_addr == `CRS_OFS_IER) begin
        int_enable_register_ff <= {i_reg_wdata[15:4], 2'b00, i_reg_wdata[1], 1'b1};
      end
      if (i_reg_wr && i_reg_addr == `CRS_OFS_VTP) begin
        vector_table_base_ff <= i_reg_wdata[`CRS_VTB_MSB:`CRS_VTB_LSB];
      end
    end
  end

  // Pipeline control outputs, registered from the next sequence position
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_flush <= 1'b1; // [RQ1]
      o_e1_hold <= 1'b1;
      o_annul <= 1'b1;
      o_force_branch <= 1'b0;
      o_branch_target <= 32'h00000000;
      o_service_start <= 1'b0;
      o_int_ack <= 1'b0;
      o_int_number_lines <= 4'h0;
    end else begin
      o_force_branch <= 1'b0;
      o_int_ack <= 1'b0;
      o_int_number_lines <= 4'h0;
      o_service_start <= 1'b0;
      o_flush <= 1'b0;
      o_e1_hold <= 1'b0;
      o_annul <= 1'b0;
      case (nxt_state)
        ST_RESET: begin
          o_flush <= (nxt_rst_cnt < `CRS_RST_FLAG_SET);
          // Nothing enters execute through cycle 22
          o_e1_hold <= 1'b1; // [RQ3] [RQ9]
          o_annul <= (nxt_rst_cnt < `CRS_RST_FLAG_SET);
          if (nxt_rst_cnt == `CRS_RST_ACK) begin
            o_force_branch <= 1'b1; // [RQ4]
            o_branch_target <= {vector_table_base_ff, 10'h000};
            o_int_ack <= 1'b1; // [RQ5]
            o_int_number_lines <= `CRS_NUM_RESET;
          end
        end
        ST_TAKE: begin
          // Seven overhead steps with the execute stage starved
          o_e1_hold <= (nxt_step <= `CRS_TAKE_HOLD_LAST); // [RQ8]
          o_annul <= (nxt_step <= `CRS_TAKE_HOLD_LAST); // [RQ15]
          if (nxt_step == `CRS_TAKE_ACK) begin
            o_force_branch <= 1'b1;
            o_branch_target <= {vector_table_base_ff, 1'b0, num_ff, 5'h00};
            o_int_ack <= 1'b1;
            o_int_number_lines <= num_ff;
          end
          if (nxt_step == `CRS_TAKE_SERVICE) begin
            o_service_start <= 1'b1; // [RQ9]
          end
        end
        default: begin
          if (state_ff == ST_RESET) begin
            o_service_start <= 1'b1; // [RQ9]
          end
        end
      endcase
    end
  end

  // Register read port, data in the following cycle
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= 32'h00000000;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `CRS_OFS_CTRL: o_reg_rdata <= {29'h0000000, nonmaskable_enable_ff, prev_global_enable_ff,
                                       global_int_enable_ff};
        `CRS_OFS_IER: o_reg_rdata <= {16'h0000, int_enable_register_ff};
        `CRS_OFS_IFR: o_reg_rdata <= {16'h0000, int_flag_register_ff};
        `CRS_OFS_VTP: o_reg_rdata <= vector_table_pointer;
        `CRS_OFS_IRP: o_reg_rdata <= irp_ff;
        `CRS_OFS_NRP: o_reg_rdata <= nonmaskable_return_pointer_ff;
        default: o_reg_rdata <= 32'h00000000;
      endcase
    end else begin
      o_reg_rdata <= 32'h00000000;
    end
  end

endmodule // crs_sequencer

`default_nettype wire

// >>> tb/crs_sequencer_properties.sv
/*
  Port checker for the reset and interrupt sequencer.
  Assumes a bind to crs_sequencer; one clock, reset active high.
*/
`timescale 1ns/1ps
`default_nettype none
module crs_sequencer_props (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Watched ports
  input wire logic i_mem_stall,
  input wire logic o_flush,
  input wire logic o_e1_hold,
  input wire logic o_annul,
  input wire logic o_force_branch,
  input wire logic [31:0] o_branch_target,
  input wire logic o_service_start,
  input wire logic o_int_ack,
  input wire logic [3:0] o_int_number_lines
);
  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;
  // Cycles since reset release, saturating
  assign nxt_cnt = (cnt_ff == 5'h1f) ? cnt_ff : cnt_ff + 5'h01;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) cnt_ff <= 5'h00;
    else cnt_ff <= nxt_cnt;
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  sequence take_body;
    (o_e1_hold && o_annul)[*6] ##1 (o_service_start && !o_e1_hold);
  endsequence
  sequence reset_tail;
    o_e1_hold ##1 (o_service_start && !o_e1_hold);
  endsequence
  a_reset_flush: assert property (cnt_ff inside {[5'd1:5'd14]} |-> o_flush && o_annul)
    else $error("flush or annul low early after reset");
  a_reset_window: assert property (cnt_ff inside {[5'd15:5'd21]} |-> o_e1_hold && !o_flush)
    else $error("reset hold window wrong");
  a_reset_vector: assert property (cnt_ff == 5'd16 |-> o_int_ack && o_force_branch && o_int_number_lines == 4'h0)
    else $error("reset branch or acknowledge missing");
  a_reset_service: assert property (cnt_ff == 5'd22 |-> reset_tail)
    else $error("reset service start late or early");
  a_take_overhead: assert property (disable iff (i_rst || i_mem_stall)
    $rose(o_int_ack) && cnt_ff > 5'd23 |-> take_body)
    else $error("take overhead not seven cycles");
  a_take_latency: assert property (disable iff (i_rst || i_mem_stall)
    $rose(o_e1_hold) && !o_flush |=> $rose(o_int_ack) && o_force_branch)
    else $error("acknowledge not one cycle after take");
  a_vector_code: assert property ($rose(o_int_ack) |-> o_branch_target[9:0] == {1'b0, o_int_number_lines, 5'h00})
    else $error("branch target does not match number");
  a_ack_pulse: assert property (disable iff (i_rst || i_mem_stall) o_int_ack |=> !o_int_ack)
    else $error("acknowledge longer than one cycle");
  a_num_idle: assert property (!o_int_ack |-> o_int_number_lines == 4'h0)
    else $error("number lines set without acknowledge");
  a_stall_freeze: assert property (o_int_ack && i_mem_stall |=> o_int_ack)
    else $error("acknowledge moved during stall");
endmodule // crs_sequencer_props
`default_nettype wire

// >>> tb/crs_int_source.sv
/*
  Interrupt source model: a fire request becomes a one-cycle pulse on a line.
  Assumes requests come on the rising edge of the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module crs_int_source (
  // Clock
  input wire logic i_core_clk,
  // Request
  input wire logic i_fire,
  input wire logic [3:0] i_num,
  // Lines
  output logic [15:0] o_int_line = 16'h0000
);
  // Low between pulses so each request is a fresh rise
  always @(posedge i_core_clk) begin
    o_int_line <= i_fire ? (16'h0001 << i_num) : 16'h0000;
  end
endmodule // crs_int_source
`default_nettype wire

// >>> tb/crs_sequencer_tb_top.sv
/*
  Testbench for the reset and interrupt sequencer: register tasks, takes, nesting.
  Assumes core/ is on the include path and the design is compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "crs_consts.vh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fails++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module crs_sequencer_tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic stall = 1'b0, bw = 1'b0, nop_later = 1'b0, ret_m = 1'b0, ret_n = 1'b0;
  logic [31:0] annul_pc = 32'h0000_1240, nop_pc = 32'h0;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0, rd_en = 1'b0, fire = 1'b0;
  logic [3:0] num = 4'h0;
  logic [15:0] lines;
  wire [31:0] rdata, target;
  wire flush, hold, annul, fbr, svc, ack;
  wire [3:0] inum;
  int fails = 0;
  int checks_done = 0;
  int k;
  crs_sequencer u_dut (.i_core_clk(core_clk), .i_rst(rst), .i_int_line(lines), .i_mem_stall(stall),
    .i_branch_window(bw), .i_annul_pc(annul_pc), .i_nop_later_cycle(nop_later), .i_nop_next_pc(nop_pc),
    .i_return_maskable(ret_m), .i_return_nonmaskable(ret_n), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr_en), .i_reg_rd(rd_en), .o_reg_rdata(rdata), .o_flush(flush), .o_e1_hold(hold),
    .o_annul(annul), .o_force_branch(fbr), .o_branch_target(target), .o_service_start(svc),
    .o_int_ack(ack), .o_int_number_lines(inum));
  crs_int_source u_src (.i_core_clk(core_clk), .i_fire(fire), .i_num(num), .o_int_line(lines));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic complete_run();
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    @(negedge core_clk);
    `CHK(rdata, exp)
  endtask
  task automatic pulse(input logic [3:0] n);
    @(posedge core_clk);
    fire <= 1'b1;
    num <= n;
    @(posedge core_clk);
    fire <= 1'b0;
  endtask
  task automatic ret(input logic nmi);
    @(posedge core_clk);
    if (nmi) ret_n <= 1'b1;
    else ret_m <= 1'b1;
    @(posedge core_clk);
    ret_n <= 1'b0;
    ret_m <= 1'b0;
  endtask
  task automatic wait_ack(input logic [3:0] n);
    for (int i = 0; i < 40 && ack !== 1'b1; i++) @(negedge core_clk);
    if (ack !== 1'b1) begin
      fails++;
      complete_run();
    end
    `CHK(inum, n)
    `CHK(target[9:0], {1'b0, n, 5'h00})
  endtask
  task automatic no_ack(input int c);
    repeat (c) begin
      @(negedge core_clk);
      `CHK(ack, 1'b0)
    end
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    repeat (30) @(negedge core_clk);
    rd(`CRS_OFS_CTRL, 32'h0);
    rd(`CRS_OFS_IER, 32'h1);
    rd(`CRS_OFS_IFR, 32'h0);
    rd(5'h02, 32'h0);
    wr(`CRS_OFS_VTP, 32'h0000_0c00);
    rd(`CRS_OFS_VTP, 32'h0000_0c00);
    wr(`CRS_OFS_FLAG_SET, 32'h40);
    rd(`CRS_OFS_IFR, 32'h40);
    wr(`CRS_OFS_FLAG_CLR, 32'h40);
    wr(`CRS_OFS_IER, 32'h32);
    rd(`CRS_OFS_IER, 32'h33);
    pulse(4'h4);
    no_ack(12);
    rd(`CRS_OFS_IFR, 32'h10);
    wr(`CRS_OFS_CTRL, 32'h5);
    wait_ack(4'h4);
    repeat (7) @(negedge core_clk);
    rd(`CRS_OFS_CTRL, 32'h6);
    rd(`CRS_OFS_IRP, 32'h0000_1240);
    rd(`CRS_OFS_IFR, 32'h0);
    @(posedge core_clk);
    annul_pc <= 32'h0000_2000;
    pulse(4'h1);
    wait_ack(4'h1);
    repeat (7) @(negedge core_clk);
    rd(`CRS_OFS_CTRL, 32'h2);
    rd(`CRS_OFS_NRP, 32'h0000_2000);
    pulse(4'h5);
    no_ack(12);
    ret(1'b1);
    no_ack(6);
    ret(1'b0);
    wait_ack(4'h5);
    repeat (7) @(negedge core_clk);
    @(posedge core_clk);
    bw <= 1'b1;
    ret(1'b0);
    pulse(4'h4);
    no_ack(15);
    @(posedge core_clk);
    bw <= 1'b0;
    wait_ack(4'h4);
    repeat (7) @(negedge core_clk);
    ret(1'b0);
    pulse(4'h4);
    // Stall starts on the acknowledge cycle so it must stretch
    for (k = 0; k < 40 && hold !== 1'b1; k++) @(negedge core_clk);
    `CHK(hold, 1'b1)
    @(posedge core_clk);
    stall <= 1'b1;
    wait_ack(4'h4);
    repeat (10) @(posedge core_clk);
    stall <= 1'b0;
    for (k = 1; k < 30 && svc !== 1'b1; k++) @(negedge core_clk);
    `CHK(k - 1, 7)
    repeat (3) @(negedge core_clk);
    @(posedge core_clk);
    nop_later <= 1'b1;
    nop_pc <= 32'h0000_3300;
    ret(1'b0);
    pulse(4'h4);
    wait_ack(4'h4);
    repeat (7) @(negedge core_clk);
    rd(`CRS_OFS_IRP, 32'h0000_3300);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    repeat (30) @(negedge core_clk);
    rd(`CRS_OFS_CTRL, 32'h0);
    rd(`CRS_OFS_IER, 32'h1);
    rd(`CRS_OFS_VTP, 32'h0);
    complete_run();
  end
endmodule // crs_sequencer_tb_top
bind crs_sequencer crs_sequencer_props u_props (.i_core_clk(i_core_clk), .i_rst(i_rst),
  .i_mem_stall(i_mem_stall), .o_flush(o_flush), .o_e1_hold(o_e1_hold), .o_annul(o_annul),
  .o_force_branch(o_force_branch), .o_branch_target(o_branch_target), .o_service_start(o_service_start),
  .o_int_ack(o_int_ack), .o_int_number_lines(o_int_number_lines));
`default_nettype wire
